// >>> rtl/dcc_pkg.sv
// ==========================================================
// Shared constants and types of the call conditioner.
// ==========================================================
package dcc_pkg;

  // ========================================================
  // Timing.
  // ========================================================
  // System clock rate in hertz.
  localparam int CLK_HZ = 10_000_000;
  // Resolution of the delay and extend timers in milliseconds.
  localparam int TICK_MS = 100;
  // Clock cycles in one timer tick.
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  // Lowest rate of fresh video frames per second.
  localparam int FRAME_HZ = 30;
  // Longest allowed gap between frames, rounded down.
  localparam int FRAME_CYC = CLK_HZ / FRAME_HZ;
  // Width of one pulse-mode call in milliseconds.
  localparam int PULSE_MS = 50;
  // Clock cycles in one pulse-mode call.
  localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);

  // ========================================================
  // Register map.
  // ========================================================
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] OCC_OFS = 12'h008;
  localparam logic [11:0] ZONE_OFS = 12'h020;
  // Control bits.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NOGATE_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // Status bits above the call vector.
  localparam int STAT_FAIL_BIT = 16;
  localparam int STAT_LATE_BIT = 17;
  localparam int STAT_CAM_BIT = 18;
  // Direction flags sit above occupancy in the OCC word.
  localparam int OCC_DIR_LSB = 16;
  // Width and reset value of a zone configuration word.
  localparam int CFG_W = 24;
  localparam logic [23:0] CFG_RST = 24'h000000;

  // ========================================================
  // Modes and states.
  // ========================================================
  // Call timing mode; codes five to seven act as plain.
  typedef enum logic [2:0] {
    TM_NONE = 3'h0,
    TM_FULL = 3'h1,
    TM_NORM = 3'h2,
    TM_EXT = 3'h3,
    TM_DLYEXT = 3'h4
  } dcc_tmode_t;

  // Detector function of a zone.
  typedef enum logic [1:0] {
    FN_PRES = 2'h0,
    FN_DPRES = 2'h1,
    FN_PULSE = 2'h2,
    FN_DPULSE = 2'h3
  } dcc_func_t;

  // Zone timing engine states.
  typedef enum logic [1:0] {
    ZS_IDLE = 2'h0,
    ZS_DELAY = 2'h1,
    ZS_HOLD = 2'h2,
    ZS_EXT = 2'h3
  } dcc_zst_t;

  // Zone configuration word, bit 0 at the bottom of tmode.
  typedef struct packed {
    logic [2:0] phase;
    logic [7:0] ext;
    logic [7:0] dly;
    dcc_func_t func;
    dcc_tmode_t tmode;
  } dcc_cfg_t;

endpackage : dcc_pkg

// >>> rtl/dcc_sync.sv
`timescale 1ns/1ns
// ==========================================================
// Two-stage synchroniser for pin inputs.
// ==========================================================
module dcc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins and their synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Both stages; the first is read only by the second.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dcc_sync_state_t;

  dcc_sync_state_t state_q;
  dcc_sync_state_t state_d;

  // Shift the pins through both stages.
  always_comb
  begin
    state_d.s1 = d;
    state_d.s2 = state_q.s1;
  end

  // Register the stages; reset to zero.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign q = state_q.s2;

endmodule : dcc_sync

// >>> rtl/dcc_zone.sv
`timescale 1ns/1ns
// ==========================================================
// Delay and extend timing engine of one zone.
// ==========================================================
module dcc_zone (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Timer tick, detection and phase state.
  input wire logic tick,
  input wire logic det,
  input wire logic green,
  input wire logic no_gate,
  input wire dcc_pkg::dcc_cfg_t cfg,
  // Conditioned call.
  output logic call
);

  // Engine state and its shared tick counter.
  typedef struct packed {
    dcc_pkg::dcc_zst_t st;
    logic [7:0] cnt;
  } dcc_zone_state_t;

  dcc_zone_state_t state_q;
  dcc_zone_state_t state_d;
  logic run; // Delay timer may count.
  logic has_dly; // Mode uses a delay.
  logic has_ext; // Mode uses an extend.

  // Decode the mode and step the engine.
  always_comb
  begin
    state_d = state_q;
    has_dly = 1'b0;
    has_ext = 1'b0;
    run = 1'b1; // Full time delay always counts.
    unique case (cfg.tmode)
      dcc_pkg::TM_FULL: has_dly = 1'b1;
      dcc_pkg::TM_NORM:
      begin
        has_dly = 1'b1;
        run = !green || no_gate; // Frozen on green.
      end
      dcc_pkg::TM_EXT: has_ext = 1'b1;
      dcc_pkg::TM_DLYEXT:
      begin
        has_dly = 1'b1;
        has_ext = 1'b1;
      end
      default: has_dly = 1'b0;
    endcase
    unique case (state_q.st)
      dcc_pkg::ZS_IDLE:
        if (det && has_dly && cfg.dly != 8'h00)
        begin
          // Call only after the delay runs out.
          state_d.st = dcc_pkg::ZS_DELAY;
          state_d.cnt = cfg.dly;
        end
        else if (det)
          state_d.st = dcc_pkg::ZS_HOLD;
      dcc_pkg::ZS_DELAY:
        if (!det)
          state_d.st = dcc_pkg::ZS_IDLE;
        else if (run && tick)
        begin
          if (state_q.cnt <= 8'h01)
            state_d.st = dcc_pkg::ZS_HOLD;
          else
            state_d.cnt = state_q.cnt - 8'h01;
        end
      dcc_pkg::ZS_HOLD:
        if (!det && has_ext && cfg.ext != 8'h00)
        begin
          // Hold the call for the extend time.
          state_d.st = dcc_pkg::ZS_EXT;
          state_d.cnt = cfg.ext;
        end
        else if (!det)
          state_d.st = dcc_pkg::ZS_IDLE;
      dcc_pkg::ZS_EXT:
        if (det)
          state_d.st = dcc_pkg::ZS_HOLD; // Re-entry restarts.
        else if (tick)
        begin
          if (state_q.cnt <= 8'h01)
            state_d.st = dcc_pkg::ZS_IDLE;
          else
            state_d.cnt = state_q.cnt - 8'h01;
        end
    endcase
  end

  // Register the engine.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_q <= '{st: dcc_pkg::ZS_IDLE, cnt: 8'h00};
    else
      state_q <= state_d;
  end

  assign call = (state_q.st == dcc_pkg::ZS_HOLD)
    || (state_q.st == dcc_pkg::ZS_EXT);

  // ========================================================
  // Checks.
  // ========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  full_delay_count_a: assert property (
    state_q.st == dcc_pkg::ZS_DELAY && cfg.tmode == dcc_pkg::TM_FULL
    && det && tick && state_q.cnt > 8'h01
    |=> state_q.cnt == $past(state_q.cnt) - 8'h01)
    else $error("Full time delay did not count.");

  green_gate_a: assert property (
    state_q.st == dcc_pkg::ZS_DELAY && cfg.tmode == dcc_pkg::TM_NORM
    && green && !no_gate && det
    |=> state_q.cnt == $past(state_q.cnt) && !call)
    else $error("Delay counted during green.");

  extend_start_a: assert property (
    state_q.st == dcc_pkg::ZS_HOLD && !det && has_ext
    && cfg.ext != 8'h00 |=> state_q.st == dcc_pkg::ZS_EXT && call)
    else $error("Call dropped instead of extending.");

  extend_restart_a: assert property (
    state_q.st == dcc_pkg::ZS_EXT && det
    |=> state_q.st == dcc_pkg::ZS_HOLD ##1 call)
    else $error("Re-entry did not hold the call.");

  delay_first_a: assert property (
    state_q.st == dcc_pkg::ZS_IDLE && det && has_dly
    && cfg.dly > 8'h01 |=> !call [*2])
    else $error("Call passed before the delay.");

endmodule : dcc_zone

// >>> rtl/dcc_top.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// - Full time delay counts regardless of phase.
// - Normal delay freezes while phase green.
// - Extend holds call after vehicle leaves.
// - Delay/extend accepts calls after delay expiry.
// - Delay/extend holds until empty plus extend.
// - Re-entry during extend restarts extend timer.
// - After extend expiry, delay must expire again.
// - Each zone picks one of four functions.
// - At least eight independent, overlapping zones.
// - At least eight call outputs per camera.
// - Call within 112 ms of arrival.
// - Zone configurations editable at any time.
// - Camera or power failure forces constant calls.
// - Fresh video at least thirty times per second.
module dcc_top #(
  parameter int NZ = 8,
  parameter int TICK_CYC = dcc_pkg::TICK_CYC,
  parameter int FRAME_CYC = dcc_pkg::FRAME_CYC,
  parameter int PULSE_CYC = dcc_pkg::PULSE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Zone results from the video logic.
  input wire logic frame_strobe,
  input wire logic [NZ-1:0] zone_occ,
  input wire logic [NZ-1:0] zone_dir_ok,
  // Pins from the camera and the controller.
  input wire logic camera_ok,
  input wire logic [7:0] phase_green,
  // Detector calls to the controller.
  output logic [NZ-1:0] call_out
);

  // ========================================================
  // Declarations.
  // ========================================================
  // Counter widths.
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int FW = $clog2(FRAME_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  // The whole state of the block.
  typedef struct packed {
    logic en; // Calls follow the zones.
    logic no_gate; // Normal delay ignores green.
    dcc_pkg::dcc_cfg_t [NZ-1:0] cfg; // Per-zone setup.
    logic [NZ-1:0] occ; // Occupancy of the last frame.
    logic [NZ-1:0] dir; // Direction flags of the last frame.
    logic [NZ-1:0] prev; // Qualified occupancy seen before.
    logic [NZ-1:0][PW-1:0] pcnt; // Pulse time left.
    logic [TW-1:0] tcnt; // Tick divider.
    logic tick; // One-cycle timer tick.
    logic [FW-1:0] fcnt; // Cycles since the last frame.
    logic late; // Frames have stopped.
    logic [NZ-1:0] call; // Calls to the controller.
    logic fail; // Fail-safe is active.
    logic pready; // APB ready.
    logic pslverr; // APB error.
    logic [31:0] prdata; // APB read data.
  } dcc_top_state_t;

  dcc_top_state_t state_q; // Registered state.
  dcc_top_state_t state_d; // Next state.
  logic [8:0] pins_s; // Synchronised pins.
  logic cam_ok_s; // Camera reports good video.
  logic [7:0] green_s; // Phases now green.
  logic [NZ-1:0] det; // Detection fed to each engine.
  logic [NZ-1:0] zcall; // Engine calls.
  logic [NZ-1:0] qual; // Occupancy qualified by direction.
  logic [9:0] widx; // Zone index of the address.
  logic zhit; // Address names a zone word.
  logic hit; // Address names any register.
  logic [31:0] rd; // Read data of the address.

  // ========================================================
  // Pin synchronisers.
  // ========================================================
  // The camera and phase pins come from outside the clock.
  dcc_sync #(
    .W(9)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({camera_ok, phase_green}),
    .q(pins_s)
  );

  assign cam_ok_s = pins_s[8];
  assign green_s = pins_s[7:0];

  // ========================================================
  // Zone engines.
  // ========================================================
  // Each zone owns its engine, so zones may overlap freely.
  for (genvar i = 0; i < NZ; i++)
  begin : g_zone
    dcc_zone u_zone (
      .clk(clk),
      .reset_n(reset_n),
      .tick(state_q.tick),
      .det(det[i]),
      .green(green_s[state_q.cfg[i].phase]),
      .no_gate(state_q.no_gate),
      .cfg(state_q.cfg[i]),
      .call(zcall[i])
    );
  end

  // ========================================================
  // Address decode and read data.
  // ========================================================
  // Decode the address and pick the word it names.
  always_comb
  begin
    widx = 10'((paddr - dcc_pkg::ZONE_OFS) >> 2);
    zhit = (paddr >= dcc_pkg::ZONE_OFS) && (widx < 10'(NZ))
      && (paddr[1:0] == 2'h0);
    hit = zhit;
    rd = 32'h0000_0000;
    if (paddr == dcc_pkg::CTRL_OFS)
    begin
      // Control word.
      hit = 1'b1;
      rd[dcc_pkg::CTRL_EN_BIT] = state_q.en;
      rd[dcc_pkg::CTRL_NOGATE_BIT] = state_q.no_gate;
    end
    else if (paddr == dcc_pkg::STAT_OFS)
    begin
      // Live calls and fault flags.
      hit = 1'b1;
      rd[NZ-1:0] = state_q.call;
      rd[dcc_pkg::STAT_FAIL_BIT] = state_q.fail;
      rd[dcc_pkg::STAT_LATE_BIT] = state_q.late;
      rd[dcc_pkg::STAT_CAM_BIT] = !cam_ok_s;
    end
    else if (paddr == dcc_pkg::OCC_OFS)
    begin
      // Frame occupancy and direction flags.
      hit = 1'b1;
      rd[NZ-1:0] = state_q.occ;
      rd[dcc_pkg::OCC_DIR_LSB +: NZ] = state_q.dir;
    end
    else if (zhit)
    begin
      // Zone configuration word.
      rd[dcc_pkg::CFG_W-1:0] = state_q.cfg[widx[$clog2(NZ)-1:0]];
    end
  end

  // ========================================================
  // Next-state logic.
  // ========================================================
  // Ticks, frames, detection shaping, fail-safe and APB.
  always_comb
  begin
    state_d = state_q;
    qual = '0;
    det = '0;
    // Tick divider for the delay and extend timers.
    if (state_q.tcnt >= TW'(TICK_CYC - 1))
    begin
      state_d.tcnt = '0;
      state_d.tick = 1'b1;
    end
    else
    begin
      state_d.tcnt = state_q.tcnt + TW'(1);
      state_d.tick = 1'b0;
    end
    // Take new occupancy once per frame.
    if (frame_strobe)
    begin
      state_d.occ = zone_occ;
      state_d.dir = zone_dir_ok;
      state_d.fcnt = '0;
      state_d.late = 1'b0;
    end
    else if (state_q.fcnt >= FW'(FRAME_CYC - 1))
      state_d.late = 1'b1; // Video has gone stale.
    else
      state_d.fcnt = state_q.fcnt + FW'(1);
    // Shape detection by the function of each zone.
    for (int i = 0; i < NZ; i++)
    begin
      qual[i] = state_q.occ[i];
      if (state_q.cfg[i].func == dcc_pkg::FN_DPRES
          || state_q.cfg[i].func == dcc_pkg::FN_DPULSE)
        qual[i] = state_q.occ[i] && state_q.dir[i];
      state_d.prev[i] = qual[i];
      if (state_q.cfg[i].func == dcc_pkg::FN_PULSE
          || state_q.cfg[i].func == dcc_pkg::FN_DPULSE)
      begin
        // One fixed pulse per arrival.
        det[i] = state_q.pcnt[i] != '0;
        if (qual[i] && !state_q.prev[i])
          state_d.pcnt[i] = PW'(PULSE_CYC);
        else if (state_q.pcnt[i] != '0)
          state_d.pcnt[i] = state_q.pcnt[i] - PW'(1);
      end
      else
      begin
        // Presence follows the zone.
        det[i] = qual[i];
        state_d.pcnt[i] = '0;
      end
    end
    // Camera loss, stale video or disable force calls.
    state_d.fail = !cam_ok_s || state_q.late || !state_q.en;
    if (state_q.fail)
      state_d.call = '1;
    else
      state_d.call = zcall; // Two cycles after a frame.
    // APB answers one cycle into the access phase.
    state_d.pready = 1'b0;
    state_d.pslverr = 1'b0;
    if (psel && penable && !state_q.pready)
    begin
      state_d.pready = 1'b1;
      state_d.pslverr = !hit;
      state_d.prdata = rd;
    end
    // Writes land at the edge that sees pready high.
    if (psel && penable && state_q.pready && pwrite)
    begin
      if (paddr == dcc_pkg::CTRL_OFS)
      begin
        state_d.en = pwdata[dcc_pkg::CTRL_EN_BIT];
        state_d.no_gate = pwdata[dcc_pkg::CTRL_NOGATE_BIT];
      end
      else if (zhit)
      begin
        // Edits apply to the running engine at once.
        state_d.cfg[widx[$clog2(NZ)-1:0]] =
          dcc_pkg::dcc_cfg_t'(pwdata[dcc_pkg::CFG_W-1:0]);
      end
    end
  end

  // ========================================================
  // State register.
  // ========================================================
  // Calls come up asserted so a restart is fail-safe.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.en <= dcc_pkg::CTRL_RST[dcc_pkg::CTRL_EN_BIT];
      state_q.call <= '1;
      state_q.fail <= 1'b1;
      for (int i = 0; i < NZ; i++)
        state_q.cfg[i] <= dcc_pkg::dcc_cfg_t'(dcc_pkg::CFG_RST);
    end
    else
      state_q <= state_d;
  end

  // Outputs come straight from the state register.
  assign call_out = state_q.call;
  assign pready = state_q.pready;
  assign prdata = state_q.prdata;
  assign pslverr = state_q.pslverr;

  // ========================================================
  // Checks.
  // ========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  fail_safe_a: assert property (
    !cam_ok_s |=> state_q.fail ##1 (call_out == {NZ{1'b1}}))
    else $error("Camera loss did not force calls.");

  frame_late_a: assert property (
    !frame_strobe && state_q.fcnt == FW'(FRAME_CYC - 1)
    |=> state_q.late)
    else $error("Missing frames were not flagged.");

  pulse_start_a: assert property (
    state_q.cfg[0].func == dcc_pkg::FN_PULSE && state_q.occ[0]
    && !state_q.prev[0] |=> state_q.pcnt[0] == PW'(PULSE_CYC))
    else $error("Arrival did not start a pulse.");

  call_latency_a: assert property (
    $rose(state_q.occ[0]) && !state_q.fail
    && state_q.cfg[0].tmode == dcc_pkg::TM_NONE
    && state_q.cfg[0].func == dcc_pkg::FN_PRES
    |-> ##[1:2] call_out[0])
    else $error("Call was late after arrival.");

  cfg_write_a: assert property (
    psel && penable && state_q.pready && pwrite
    && paddr == dcc_pkg::ZONE_OFS
    |=> state_q.cfg[0] == dcc_pkg::CFG_W'($past(pwdata)))
    else $error("Zone edit did not take effect.");

  apb_answer_a: assert property (
    psel && penable && !state_q.pready |=> pready ##1 !pready)
    else $error("APB answer was not one cycle.");

endmodule : dcc_top

// >>> bench/dcc_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================================
// Controller side: phase pins and a monitor of the calls.
// ==========================================================
module dcc_ctrl_model #(
  parameter int NZ = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Calls from the block and requests from the bench.
  input wire logic [NZ-1:0] call,
  input wire logic [7:0] green_req,
  input wire logic clr,
  // Phase pins and high-cycle counts per call.
  output logic [7:0] phase_green,
  output logic [NZ-1:0][7:0] hi_cnt
);
  // Phases go green one clock after the request, as a cabinet would.
  always_ff @(posedge clk)
  begin
    phase_green <= reset_n ? green_req : 8'h00;
  end

  // Count cycles with each call high; saturate on a held call.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NZ; i++)
    begin
      if (!reset_n || clr)
        hi_cnt[i] <= 8'h00;
      else if (call[i] && hi_cnt[i] != 8'hff)
        hi_cnt[i] <= hi_cnt[i] + 8'h01;
    end
  end
endmodule : dcc_ctrl_model

// >>> bench/dcc_top_tb.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench of the call conditioner.
// ==========================================================
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module dcc_top_tb;
  // Bench state and design pins.
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic frame_strobe = 0, camera_ok = 1, frames_on = 0, clr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er;
  logic [7:0] zone_occ = 0, zone_dir_ok = 0, green_req = 0;
  logic [7:0] phase_green, call_out;
  logic [7:0][7:0] hi_cnt;
  logic [3:0] fcnt = 0;
  int n_fail = 0, n_checks = 0, cyc = 0, n, bad;

  // 100 ns clock.
  always #50 clk = ~clk;

  // Video logic stand-in: one frame strobe every ten cycles.
  always @(posedge clk)
  begin
    fcnt <= (fcnt == 4'h9) ? 4'h0 : fcnt + 4'h1;
    frame_strobe <= frames_on && fcnt == 4'h9;
  end

  // Hang guard.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  // ========================================================
  // Design and partner.
  // ========================================================
  dcc_top #(.NZ(8), .TICK_CYC(4), .FRAME_CYC(50), .PULSE_CYC(3))
    dcc_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .frame_strobe(frame_strobe),
    .zone_occ(zone_occ), .zone_dir_ok(zone_dir_ok),
    .camera_ok(camera_ok), .phase_green(phase_green),
    .call_out(call_out));

  dcc_ctrl_model #(.NZ(8)) dcc_ctrl_model_inst (.clk(clk),
    .reset_n(reset_n), .call(call_out), .green_req(green_req),
    .clr(clr), .phase_green(phase_green), .hi_cnt(hi_cnt));

  // ========================================================
  // Shared tasks.
  // ========================================================
  // One APB transfer; the request holds until pready is seen.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Zone configuration word with phase index zero.
  function automatic dcc_pkg::dcc_cfg_t mk(dcc_pkg::dcc_tmode_t t,
    dcc_pkg::dcc_func_t f, logic [7:0] d, logic [7:0] e);
    mk = {3'h0, e, d, f, t};
  endfunction : mk

  task automatic setz(input int z, input dcc_pkg::dcc_cfg_t c);
    apb(1'b1, dcc_pkg::ZONE_OFS + 12'(4 * z), {8'h00, c});
  endtask : setz

  // Change occupancy just after a strobe, so the next frame takes it.
  task automatic occ(input logic [7:0] m, input logic v);
    do @(posedge clk); while (frame_strobe !== 1'b1);
    zone_occ <= v ? (zone_occ | m) : (zone_occ & ~m);
  endtask : occ

  task automatic skip(input int c);
    repeat (c) @(posedge clk);
  endtask : skip

  // Wait up to lim cycles for a call to reach level v.
  task automatic wait_call(input int z, input logic v, input int lim);
    n = 0;
    while (call_out[z] !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_call

  // Count cycles within c where the call is not at level v.
  task automatic hold(input int z, input logic v, input int c);
    bad = 0;
    repeat (c)
    begin
      @(posedge clk);
      if (call_out[z] !== v)
        bad++;
    end
  endtask : hold

  // ========================================================
  // Scenarios.
  // ========================================================
  // Reset values, an unmapped place and an edited zone.
  task automatic t_regs();
    apb(1'b0, dcc_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", dcc_pkg::CTRL_RST, rd)
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 1'b1, er)
    setz(0, mk(dcc_pkg::TM_EXT, dcc_pkg::FN_DPULSE, 8'h5a, 8'ha5));
    apb(1'b0, dcc_pkg::ZONE_OFS, 32'h0);
    `CHK("zone0", {8'h00, 24'h14ab5b}, rd)
    setz(0, mk(dcc_pkg::TM_NONE, dcc_pkg::FN_PRES, 8'h00, 8'h00));
    setz(1, mk(dcc_pkg::TM_EXT, dcc_pkg::FN_PRES, 8'h00, 8'h03));
    setz(2, mk(dcc_pkg::TM_FULL, dcc_pkg::FN_PRES, 8'h03, 8'h00));
    setz(3, mk(dcc_pkg::TM_NORM, dcc_pkg::FN_PRES, 8'h03, 8'h00));
    setz(4, mk(dcc_pkg::TM_DLYEXT, dcc_pkg::FN_PRES, 8'h02, 8'h05));
    setz(5, mk(dcc_pkg::TM_NONE, dcc_pkg::FN_PULSE, 8'h00, 8'h00));
    setz(6, mk(dcc_pkg::TM_NONE, dcc_pkg::FN_DPULSE, 8'h00, 8'h00));
    setz(7, mk(dcc_pkg::TM_NONE, dcc_pkg::FN_DPRES, 8'h00, 8'h00));
  endtask : t_regs

  // Presence, extend, and the two delays under a green phase.
  task automatic t_timing();
    occ(8'h01, 1'b1);
    wait_call(0, 1'b1, 20);
    `CHK("pres", 1'b1, call_out[0])
    occ(8'h01, 1'b0);
    occ(8'h02, 1'b1);
    wait_call(1, 1'b1, 20);
    occ(8'h02, 1'b0);
    skip(16);
    `CHK("ext_held", 1'b1, call_out[1])
    wait_call(1, 1'b0, 15);
    `CHK("ext_end", 1'b0, call_out[1])
    green_req <= 8'h01;
    occ(8'h0c, 1'b1);
    `CHK("full_early", 1'b0, call_out[2])
    wait_call(2, 1'b1, 30);
    `CHK("full_green", 1'b1, call_out[2])
    skip(40);
    `CHK("norm_green", 1'b0, call_out[3])
    green_req <= 8'h00;
    wait_call(3, 1'b1, 30);
    `CHK("norm_red", 1'b1, call_out[3])
    occ(8'h0c, 1'b0);
  endtask : t_timing

  // Combined delay and extend with a re-entry during extend.
  task automatic t_dlyext();
    occ(8'h10, 1'b1);
    skip(12);
    `CHK("de_delay", 1'b0, call_out[4])
    wait_call(4, 1'b1, 30);
    `CHK("de_call", 1'b1, call_out[4])
    occ(8'h10, 1'b0);
    occ(8'h10, 1'b1);
    hold(4, 1'b1, 25);
    `CHK("de_reenter", 0, bad)
    occ(8'h10, 1'b0);
    hold(4, 1'b1, 14);
    `CHK("de_hold", 0, bad)
    wait_call(4, 1'b0, 20);
    `CHK("de_end", 1'b0, call_out[4])
    occ(8'h10, 1'b1);
    skip(12);
    `CHK("de_redelay", 1'b0, call_out[4])
    wait_call(4, 1'b1, 30);
    `CHK("de_again", 1'b1, call_out[4])
    occ(8'h10, 1'b0);
  endtask : t_dlyext

  // Pulse, directional pulse and directional presence, with and without the right direction.
  task automatic t_func();
    for (int k = 0; k < 2; k++)
    begin
      zone_dir_ok <= k ? 8'hc0 : 8'h00;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      occ(8'he0, 1'b1);
      skip(30);
      `CHK("pulse", 8'h03, hi_cnt[5])
      `CHK("dpulse", k ? 8'h03 : 8'h00, hi_cnt[6])
      `CHK("dpres", k == 1, hi_cnt[7] > 8'h0c)
      occ(8'he0, 1'b0);
      skip(20);
    end
  endtask : t_func

  // Camera failure and missing frames force every call on.
  task automatic t_fail();
    `CHK("zones", 8, $bits(call_out))
    camera_ok <= 1'b0;
    skip(6);
    `CHK("cam_fail", 8'hff, call_out)
    camera_ok <= 1'b1;
    skip(25);
    `CHK("cam_back", 8'h00, call_out)
    frames_on <= 1'b0;
    skip(60);
    `CHK("late", 8'hff, call_out)
    apb(1'b0, dcc_pkg::STAT_OFS, 32'h0);
    `CHK("late_bit", 1'b1, rd[dcc_pkg::STAT_LATE_BIT])
    frames_on <= 1'b1;
    skip(25);
    `CHK("resume", 8'h00, call_out)
  endtask : t_fail

  // Prints the counts and the verdict, then ends the run.
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk);
    `CHK("call_rst", 8'hff, call_out)
    reset_n <= 1'b1;
    frames_on <= 1'b1;
    t_regs();
    skip(30);
    `CHK("idle", 8'h00, call_out)
    t_timing();
    t_dlyext();
    t_func();
    t_fail();
    give_verdict();
  end
endmodule : dcc_top_tb
